// ---- logic/pdbs_pkg.sv ----
// Purpose: Shared constants for the PWM duty brightness sampler
// Assumes: 50 MHz system clock, 8-bit register port
// Notes:   Sample window length is a power of two so the ratio is a bit slice
package pdbs_pkg;
    localparam logic [7:0] PDBS_ADDR_CUR_A      = 8'h05;
    localparam logic [7:0] PDBS_ADDR_FILTER     = 8'h50;
    localparam logic [7:0] PDBS_ADDR_DUTY_LO    = 8'h12;
    localparam logic [7:0] PDBS_ADDR_DUTY_HI    = 8'h13;
    localparam int         PDBS_RELAX_BIT       = 7;
    localparam int         PDBS_FLOOR_DIS_BIT   = 6;
    localparam logic [7:0] PDBS_CUR_A_RESET     = 8'h00;
    localparam logic [1:0] PDBS_FILTER_RESET    = 2'h0;
    localparam logic [8:0] PDBS_HYST_STEP       = 9'h003;
    localparam logic [7:0] PDBS_FLOOR_CODE      = 8'h06;
    localparam logic [7:0] PDBS_OFF_MAX         = 8'h01;
    localparam logic [7:0] PDBS_CODE_MAX        = 8'hFF;
    localparam int         PDBS_CLK_PERIOD_NS   = 20;
    localparam int         PDBS_SAMPLE_NS       = 81920;
    localparam int         PDBS_SAMPLE_CYCLES   = PDBS_SAMPLE_NS / PDBS_CLK_PERIOD_NS;
    localparam int         PDBS_WIN_LOG2        = $clog2(PDBS_SAMPLE_CYCLES);
endpackage : pdbs_pkg

// ---- logic/pdbs_sampler.sv ----
// Purpose: Measures PWM input duty and turns it into a brightness code for the banks
// Assumes: Register port already decoded from the serial interface; pwm_in synchronous
// Notes:   Fixed window sampling; low input frequencies give a coarser, less stable code
`timescale 1ns/1ps
module pdbs_sampler
    import pdbs_pkg::*;
#(
    parameter int WIN_LOG2 = PDBS_WIN_LOG2
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       pwm_in,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       bank_a_pwm_en,
    input  wire logic       bank_b_pwm_en,
    input  wire logic [7:0] bank_a_brightness,
    input  wire logic [7:0] bank_b_brightness,
    output logic [7:0]      reg_rdata,
    output logic [7:0]      sampler_code,
    output logic [7:0]      bank_a_level,
    output logic [7:0]      bank_b_level,
    output logic [4:0]      bank_a_full_scale
);

    function automatic logic [7:0] pdbs_scale(input logic [7:0] bright, input logic [7:0] code);
        logic [15:0] prod;
        prod = {8'h00, bright} * ({8'h00, code} + 16'h0001);
        return prod[15:8];
    endfunction : pdbs_scale

    logic [7:0]          cur_a_reg;
    logic [1:0]          filter_reg;
    logic [WIN_LOG2-1:0] win_cnt_reg;
    logic [WIN_LOG2:0]   high_cnt_reg;
    logic [8:0]          duty_reg;
    logic [2:0]          period_cnt_reg;
    logic [7:0]          code_reg;
    logic [7:0]          rdata_reg;
    logic [7:0]          level_a_reg;
    logic [7:0]          level_b_reg;

    wire                 relax     = cur_a_reg[PDBS_RELAX_BIT];
    wire                 floor_dis = cur_a_reg[PDBS_FLOOR_DIS_BIT];
    wire                 win_end   = &win_cnt_reg;
    // Last sample of the window is folded in so a constant-high input reads 256
    wire [WIN_LOG2:0]    high_total = high_cnt_reg + {{WIN_LOG2{1'b0}}, pwm_in};
    wire [8:0]           duty_now   = high_total[WIN_LOG2 -: 9];
    wire [7:0]           det        = duty_now[8] ? PDBS_CODE_MAX : duty_now[7:0];
    wire [2:0]           filt_mask  = (filter_reg == 2'h0) ? 3'h0 :
                                      (filter_reg == 2'h1) ? 3'h1 :
                                      (filter_reg == 2'h2) ? 3'h3 : 3'h7;
    wire                 allow      = (period_cnt_reg & filt_mask) == 3'h0;
    wire                 update     = clk_en && win_end && allow;
    // Floor stage: 0..1 off, 2..6 lifted to 6, above passes
    wire [7:0]           cand       = floor_dis ? det :
                                      (det <= PDBS_OFF_MAX) ? 8'h00 :
                                      (det <= PDBS_FLOOR_CODE) ? PDBS_FLOOR_CODE :
                                      det;
    // Upward steps need a margin unless relaxed; falls always follow
    wire                 rise_ok    = relax ? (cand > code_reg) :
                                      ({1'b0, cand} >= {1'b0, code_reg} + PDBS_HYST_STEP);
    wire                 fall_ok    = cand < code_reg;
    wire [7:0]           code_next  = (update && (rise_ok || fall_ok)) ? cand : code_reg;
    wire [7:0]           level_a_next = bank_a_pwm_en ? pdbs_scale(bank_a_brightness, code_reg)
                                                      : bank_a_brightness;
    wire [7:0]           level_b_next = bank_b_pwm_en ? pdbs_scale(bank_b_brightness, code_reg)
                                                      : bank_b_brightness;
    wire [7:0]           rdata_next = (reg_addr == PDBS_ADDR_CUR_A)    ? cur_a_reg :
                                      (reg_addr == PDBS_ADDR_FILTER)   ? {6'h00, filter_reg} :
                                      (reg_addr == PDBS_ADDR_DUTY_LO)  ? duty_reg[7:0] :
                                      (reg_addr == PDBS_ADDR_DUTY_HI)  ? {7'h00, duty_reg[8]} :
                                      8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_a_reg  <= PDBS_CUR_A_RESET;
            filter_reg <= PDBS_FILTER_RESET;
            rdata_reg  <= 8'h00;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == PDBS_ADDR_CUR_A) begin
                cur_a_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == PDBS_ADDR_FILTER) begin
                filter_reg <= reg_wdata[1:0];
            end
            if (reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Window runs free; out-of-range input frequencies simply give coarser codes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            win_cnt_reg    <= '0;
            high_cnt_reg   <= '0;
            duty_reg       <= 9'h000;
            period_cnt_reg <= 3'h0;
        end else if (clk_en) begin
            win_cnt_reg  <= win_cnt_reg + 1'b1;
            high_cnt_reg <= win_end ? '0 : high_total;
            if (win_end) begin
                duty_reg       <= duty_now;
                period_cnt_reg <= period_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            code_reg    <= 8'h00;
            level_a_reg <= 8'h00;
            level_b_reg <= 8'h00;
        end else if (clk_en) begin
            code_reg    <= code_next;
            level_a_reg <= level_a_next;
            level_b_reg <= level_b_next;
        end
    end

    assign reg_rdata         = rdata_reg;
    assign sampler_code      = code_reg;
    assign bank_a_level      = level_a_reg;
    assign bank_b_level      = level_b_reg;
    assign bank_a_full_scale = cur_a_reg[4:0];

    property p_hold;
        @(posedge clk_sys) disable iff (rst) !update |=> $stable(code_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("Code moved outside update instant");

    property p_filter;
        @(posedge clk_sys) disable iff (rst) $changed(code_reg) |-> $past(allow) && $past(win_end);
    endproperty
    a_filter: assert property (p_filter) else $error("Code changed off filter cadence");

    property p_floor_off;
        @(posedge clk_sys) disable iff (rst) update && !floor_dis && det <= 8'h01 |=> code_reg == 8'h00;
    endproperty
    a_floor_off: assert property (p_floor_off) else $error("Low code not forced off");

    property p_floor_six;
        @(posedge clk_sys) disable iff (rst)
            update && !floor_dis && det >= 8'h02 && det <= 8'h06 && (code_reg == 8'h00 || code_reg == 8'h06)
            |=> code_reg == 8'h06;
    endproperty
    a_floor_six: assert property (p_floor_six) else $error("Floor code 6 not applied");

    property p_hyst_block;
        @(posedge clk_sys) disable iff (rst)
            update && !relax && cand > code_reg && ({1'b0, cand} < {1'b0, code_reg} + 9'h003)
            |=> code_reg == $past(code_reg);
    endproperty
    a_hyst_block: assert property (p_hyst_block) else $error("Small rise passed hysteresis");

    property p_relax;
        @(posedge clk_sys) disable iff (rst) update && relax && cand != code_reg |=> code_reg == $past(cand);
    endproperty
    a_relax: assert property (p_relax) else $error("Relaxed code did not follow");

    property p_duty_top;
        @(posedge clk_sys) disable iff (rst) duty_reg[8] |-> duty_reg[7:0] == 8'h00;
    endproperty
    a_duty_top: assert property (p_duty_top) else $error("Duty top bit with nonzero low");

    property p_bank_a;
        @(posedge clk_sys) disable iff (rst)
            clk_en && bank_a_pwm_en && bank_a_brightness == 8'hFF |=> bank_a_level == $past(code_reg);
    endproperty
    a_bank_a: assert property (p_bank_a) else $error("Bank A level not scaled by code");

    property p_reset;
        @(posedge clk_sys) rst |=> code_reg == 8'h00 && duty_reg == 9'h000;
    endproperty
    a_reset: assert property (p_reset) else $error("Sampler not cleared by reset");

    property p_fall;
        @(posedge clk_sys) disable iff (rst) update && cand < code_reg |=> code_reg == $past(cand);
    endproperty
    a_fall: assert property (p_fall) else $error("Falling code not followed");

    property p_low_codes;
        @(posedge clk_sys) disable iff (rst)
            update && floor_dis && relax && det != code_reg |=> code_reg == $past(det);
    endproperty
    a_low_codes: assert property (p_low_codes) else $error("Unfloored code not tracked");

    property p_pass_b;
        @(posedge clk_sys) disable iff (rst)
            clk_en && !bank_b_pwm_en |=> bank_b_level == $past(bank_b_brightness);
    endproperty
    a_pass_b: assert property (p_pass_b) else $error("Bank B level not plain brightness");

    // Frozen cycles must not advance the window, or the duty ratio would be skewed
    property p_freeze;
        @(posedge clk_sys) disable iff (rst) !clk_en |=> $stable(code_reg) && $stable(win_cnt_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while clock enable low");

    c_rise:  cover property (@(posedge clk_sys) disable iff (rst) update && rise_ok);
    c_six:   cover property (@(posedge clk_sys) disable iff (rst) update && cand == 8'h06 && code_reg == 8'h00);
    c_full:  cover property (@(posedge clk_sys) disable iff (rst) duty_reg == 9'h100);
    c_slow:  cover property (@(posedge clk_sys) disable iff (rst) update && filter_reg == 2'h3);
    c_low:   cover property (@(posedge clk_sys) disable iff (rst) update && floor_dis && cand == 8'h01);

endmodule : pdbs_sampler

// ---- verif/pdbs_pwm_source.sv ----
// Purpose: Host PWM source model feeding the sampler input
// Assumes: Period fixed at PERIOD system clocks
// Notes:   A period equal to the window keeps each window's high count exact
`timescale 1ns/1ps
module pdbs_pwm_source #(
    parameter int PERIOD = 256
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [8:0] high_cnt,
    output logic            pwm_out
);
    logic [8:0] phase_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_reg <= 9'h000;
            pwm_out   <= 1'b0;
        end else begin
            // Far above the advised band so runs stay short
            phase_reg <= (phase_reg == 9'(PERIOD - 1)) ? 9'h000 : phase_reg + 9'h001;
            pwm_out   <= (phase_reg < high_cnt); // Tiny duties are used on purpose
        end
    end
endmodule : pdbs_pwm_source

// ---- verif/tb_pwm_duty_brightness_sampler.sv ----
// Purpose: Self-checking bench for the PWM duty sampler
// Assumes: Window of 256 cycles, PWM period of 256 cycles
// Notes:   Fixed waits span three windows so every update has landed
`timescale 1ns/1ps
module tb_pwm_duty_brightness_sampler;
    import pdbs_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       clk_en = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       a_en = 1'b1;
    logic       b_en = 1'b0;
    logic [7:0] a_bri = 8'h80;
    logic [8:0] high_cnt = 9'h000;
    logic       pwm_in;
    logic [7:0] reg_rdata, code, a_lvl, b_lvl;
    logic [4:0] a_full;
    int         err_total = 0;
    int         comparisons = 0;
    int         n;
    always #10 clk_sys = ~clk_sys;
    pdbs_sampler #(.WIN_LOG2(8)) dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .pwm_in(pwm_in),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bank_a_pwm_en(a_en),
        .bank_b_pwm_en(b_en), .bank_a_brightness(a_bri), .bank_b_brightness(8'h40), .reg_rdata(reg_rdata),
        .sampler_code(code), .bank_a_level(a_lvl), .bank_b_level(b_lvl), .bank_a_full_scale(a_full));
    pdbs_pwm_source src (.clk_sys(clk_sys), .rst(rst), .high_cnt(high_cnt), .pwm_out(pwm_in));
    task automatic stop_test;
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic settle(input logic [8:0] h, input logic [7:0] exp);
        @(posedge clk_sys);
        high_cnt <= h;
        repeat (768) @(posedge clk_sys);
        #1 chk(code, exp);
    endtask : settle
    // Counts edges from the new duty to the next output change
    task automatic wait_chg(input logic [8:0] h, output int cnt);
        logic [7:0] old;
        old = code;
        @(posedge clk_sys);
        high_cnt <= h;
        cnt = 0;
        while (code === old && cnt < 5000) begin
            @(posedge clk_sys);
            #1 cnt++;
        end
        if (cnt >= 5000) begin
            err_total++;
            $display("Error at %0t: output never changed", $time);
            stop_test();
        end
    endtask : wait_chg
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(PDBS_ADDR_CUR_A, 8'h00);
        rd(PDBS_ADDR_FILTER, 8'h00);
        rd(PDBS_ADDR_DUTY_HI, 8'h00);
        rd(8'h20, 8'h00);                    // Unmapped place reads zero
        settle(9'h001, 8'h00);
        settle(9'h004, 8'h06);
        settle(9'h008, 8'h06);               // Rise of two is held back
        settle(9'h009, 8'h09);
        chk(a_lvl, 8'h05);
        chk(b_lvl, 8'h40);
        settle(9'h007, 8'h07);               // Falls are always taken
        settle(9'h100, 8'hFF);
        rd(PDBS_ADDR_DUTY_LO, 8'h00);
        rd(PDBS_ADDR_DUTY_HI, 8'h01);
        wr(PDBS_ADDR_CUR_A, 8'h94);
        rd(PDBS_ADDR_CUR_A, 8'h94);
        chk(a_full, 5'h14);
        settle(9'h014, 8'h14);
        @(posedge clk_sys);
        a_en <= 1'b0;
        b_en <= 1'b1;
        settle(9'h015, 8'h15);               // Single-code rise
        chk(a_lvl, 8'h80);
        chk(b_lvl, 8'h05);
        @(posedge clk_sys);
        a_en  <= 1'b1;
        a_bri <= 8'hFF;
        repeat (2) @(posedge clk_sys);
        #1 chk(a_lvl, 8'h15);                // Full brightness gives the code back
        wr(PDBS_ADDR_CUR_A, 8'hD4);
        settle(9'h003, 8'h03);
        settle(9'h001, 8'h01);
        rd(PDBS_ADDR_DUTY_LO, 8'h01);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(PDBS_ADDR_FILTER, 8'h02);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        rd(PDBS_ADDR_FILTER, 8'h00);         // Frozen write ignored
        wr(PDBS_ADDR_FILTER, 8'hFF);
        rd(PDBS_ADDR_FILTER, 8'h03);
        for (int f = 0; f < 4; f++) begin
            wr(PDBS_ADDR_FILTER, 8'(f));
            wait_chg(9'h064, n);
            wait_chg(9'h0C8, n);
            chk(n[15:0], 16'((256 << f) - 1));
        end
        stop_test();
    end
endmodule : tb_pwm_duty_brightness_sampler
